// file: hdl/byte_logic_decrement_exec.sv
// How it works
// - 1110 kkkk kkkk: acc = acc AND literal k, zero flag, one cycle
// - 0100 bbbf ffff: clear selected file bit, no flags change, one cycle
// - bit-clear word holds 3-bit bit position then 5-bit file address
// - 0010 01df ffff: invert file register, zero flag, one cycle
// - 0000 11df ffff: file register minus one, zero flag, one cycle
// - complement and decrement: d=0 writes accumulator, d=1 file register
`timescale 1ns/1ns
`default_nettype none

module byte_logic_decrement_exec (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        clkEn,
	input  wire logic        instrValid,
	input  wire logic [11:0] instrWord,
	input  wire logic [7:0]  fileRdData,
	output logic             fileWrEn,
	output logic [4:0]       fileWrAddr,
	output logic [7:0]       fileWrData,
	output logic [7:0]       accumulator,
	output logic             zeroFlag,
	output logic             execDone,
	output logic             instrIgnored
);

	// ************************************************************
	// decode
	// ************************************************************
	// decoded fields travel together in one bundle
	decode_if decoded ();

	// field split and opcode match live in the small decoder
	instr_decode u_decode (
		.instrWord (instrWord),
		.dec       (decoded)
	);

	// ************************************************************
	// helper functions
	// ************************************************************
	// 8-bit zero test, shared by every flag-updating operation
	function automatic logic isZero(input logic [7:0] value);
		isZero = (value == exec_pkg::DATA_ZERO);
	endfunction

	// true when the destination bit routes a result to the accumulator;
	// complement and decrement both use it
	function automatic logic destIsAcc(input logic dest);
		destIsAcc = (dest == exec_pkg::DEST_ACC);
	endfunction

	// ************************************************************
	// bit clear, one lane per data bit
	// ************************************************************
	logic [7:0] clearedByte;

	// each lane passes its bit unless the position field points at it;
	// a lane compare keeps a shifter out of the read path
	for (genvar lane = 0; lane < exec_pkg::DATA_W; lane++) begin : g_clear
		assign clearedByte[lane] =
			(decoded.bitPos == 3'(lane)) ? 1'b0 : fileRdData[lane];
	end

	// ************************************************************
	// result computation
	// ************************************************************
	logic [7:0] result;
	logic       recognised;

	// one result path per operation; fileRdData must already reflect
	// the register at decoded.fileAddr in the same cycle
	// only the zero flag lives here; no other status bit is produced
	always_comb begin
		result     = exec_pkg::DATA_ZERO;
		recognised = 1'b1;
		case (decoded.opKind)
			exec_pkg::OP_AND_LITERAL_ACC: begin
				result = accumulator & decoded.literal;
			end
			exec_pkg::OP_BIT_CLEAR_FILE: begin
				result = clearedByte;
			end
			exec_pkg::OP_COMPLEMENT_FILE: begin
				result = ~fileRdData;
			end
			exec_pkg::OP_DECREMENT_FILE: begin
				// 00 wraps to ff, which also clears the zero flag
				result = fileRdData - exec_pkg::DATA_ONE;
			end
			default: begin
				recognised = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// destination routing
	// ************************************************************
	logic toAcc;
	logic toFile;

	// literal-AND always lands in the accumulator and bit clear in the
	// file; the other two follow the destination bit
	always_comb begin
		toAcc  = 1'b0;
		toFile = 1'b0;
		case (decoded.opKind)
			exec_pkg::OP_AND_LITERAL_ACC: begin
				toAcc = 1'b1;
			end
			exec_pkg::OP_BIT_CLEAR_FILE: begin
				toFile = 1'b1;
			end
			exec_pkg::OP_COMPLEMENT_FILE,
			exec_pkg::OP_DECREMENT_FILE: begin
				toAcc  = destIsAcc(decoded.destSel);
				toFile = !destIsAcc(decoded.destSel);
			end
			default: begin
				toAcc  = 1'b0;
				toFile = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// word acceptance
	// ************************************************************
	logic take;
	logic retire;

	// a word counts only on an enabled edge with valid high; anything
	// else holds the accumulator, flag and write address and data
	always_comb begin
		take   = clkEn && instrValid;
		retire = take && recognised;
	end

	// ************************************************************
	// accumulator and zero flag
	// ************************************************************
	logic [7:0] next_accumulator;
	logic       next_zeroFlag;

	// the result written here is seen by the very next word
	always_comb begin
		next_accumulator = accumulator;
		next_zeroFlag    = zeroFlag;
		if (retire && toAcc) begin
			next_accumulator = result;
		end
		// bit clear leaves the flag alone, so only updZero words touch it
		if (retire && decoded.updZero) begin
			next_zeroFlag = isZero(result);
		end
	end

	// clkEn low freezes the accumulator and flag with the rest
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			accumulator <= exec_pkg::ACC_RESET;
			zeroFlag    <= exec_pkg::ZERO_RESET;
		end else if (clkEn) begin
			accumulator <= next_accumulator;
			zeroFlag    <= next_zeroFlag;
		end
	end

	// ************************************************************
	// file register write port
	// ************************************************************
	logic       next_fileWrEn;
	logic [4:0] next_fileWrAddr;
	logic [7:0] next_fileWrData;

	// address and data hold after a write so the file side may sample
	// them late; only the strobe is a pulse
	always_comb begin
		next_fileWrEn   = 1'b0;
		next_fileWrAddr = fileWrAddr;
		next_fileWrData = fileWrData;
		if (retire && toFile) begin
			next_fileWrEn   = 1'b1;
			next_fileWrAddr = decoded.fileAddr;
			next_fileWrData = result;
		end
	end

	// a stalled core sees the strobe held rather than lost
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fileWrEn   <= 1'b0;
			fileWrAddr <= exec_pkg::ADDR_ZERO;
			fileWrData <= exec_pkg::DATA_ZERO;
		end else if (clkEn) begin
			fileWrEn   <= next_fileWrEn;
			fileWrAddr <= next_fileWrAddr;
			fileWrData <= next_fileWrData;
		end
	end

	// ************************************************************
	// retire and ignore strobes
	// ************************************************************
	logic next_execDone;
	logic next_instrIgnored;

	// every supported word retires in exactly one enabled cycle;
	// unknown words are left to the rest of the core
	always_comb begin
		next_execDone     = retire;
		next_instrIgnored = take && !recognised;
	end

	// both are pulses of one enabled cycle
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			execDone     <= 1'b0;
			instrIgnored <= 1'b0;
		end else if (clkEn) begin
			execDone     <= next_execDone;
			instrIgnored <= next_instrIgnored;
		end
	end

endmodule

`default_nettype wire

// file: hdl/decode_if.sv
`timescale 1ns/1ns
`default_nettype none

// decoded fields passed from the decoder to the execution stage
interface decode_if;
	exec_pkg::op_kind_t opKind;
	logic [7:0]         literal;
	logic [2:0]         bitPos;
	logic [4:0]         fileAddr;
	logic               destSel;
	logic               updZero;

	modport dec (output opKind, literal, bitPos, fileAddr, destSel,
		updZero);
	modport exe (input opKind, literal, bitPos, fileAddr, destSel,
		updZero);
endinterface

`default_nettype wire

// file: hdl/exec_pkg.sv
package exec_pkg;

	// ************************************************************
	// instruction word layout (12-bit program word)
	// ************************************************************
	localparam int INSTR_W        = 12;
	localparam int DATA_W         = 8;
	localparam int ADDR_W         = 5;
	localparam int BITPOS_W       = 3;

	// field positions
	localparam int NIBBLE_MSB     = 11;
	localparam int NIBBLE_LSB     = 8;
	localparam int OP6_MSB        = 11;
	localparam int OP6_LSB        = 6;
	localparam int LITERAL_MSB    = 7;
	localparam int LITERAL_LSB    = 0;
	localparam int BITPOS_MSB     = 7;
	localparam int BITPOS_LSB     = 5;
	localparam int ADDR_MSB       = 4;
	localparam int ADDR_LSB       = 0;
	localparam int DEST_BIT       = 5;

	// opcode patterns
	localparam logic [3:0] OPC_AND_LITERAL_ACC  = 4'he;
	localparam logic [3:0] OPC_BIT_CLEAR_FILE   = 4'h4;
	localparam logic [5:0] OPC_COMPLEMENT_FILE  = 6'h09;
	localparam logic [5:0] OPC_DECREMENT_FILE   = 6'h03;

	// destination select values
	localparam logic DEST_ACC  = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// reset values
	localparam logic [7:0] ACC_RESET  = 8'h00;
	localparam logic       ZERO_RESET = 1'b0;
	localparam logic [7:0] DATA_ZERO  = 8'h00;
	localparam logic [7:0] DATA_ONE   = 8'h01;
	localparam logic [4:0] ADDR_ZERO  = 5'h00;

	// execution timing: every supported instruction takes one cycle
	localparam int EXEC_CYCLES = 1;

	// one-hot operation kinds
	typedef enum logic [4:0] {
		OP_NONE              = 5'b00001,
		OP_AND_LITERAL_ACC   = 5'b00010,
		OP_BIT_CLEAR_FILE    = 5'b00100,
		OP_COMPLEMENT_FILE   = 5'b01000,
		OP_DECREMENT_FILE    = 5'b10000
	} op_kind_t;

endpackage

// file: hdl/instr_decode.sv
`timescale 1ns/1ns
`default_nettype none

module instr_decode (
	input  wire logic [11:0] instrWord,
	decode_if.dec            dec
);

	// ************************************************************
	// field extraction and opcode match
	// ************************************************************
	// pure combinational; the caller registers everything it drives out
	always_comb begin
		dec.literal  = instrWord[exec_pkg::LITERAL_MSB:exec_pkg::LITERAL_LSB];
		dec.bitPos   =
			instrWord[exec_pkg::BITPOS_MSB:exec_pkg::BITPOS_LSB];
		dec.fileAddr =
			instrWord[exec_pkg::ADDR_MSB:exec_pkg::ADDR_LSB];
		dec.destSel  = instrWord[exec_pkg::DEST_BIT];
		dec.opKind   = exec_pkg::OP_NONE;
		dec.updZero  = 1'b0;
		if (instrWord[exec_pkg::NIBBLE_MSB:exec_pkg::NIBBLE_LSB]
				== exec_pkg::OPC_AND_LITERAL_ACC) begin
			dec.opKind  = exec_pkg::OP_AND_LITERAL_ACC;
			dec.updZero = 1'b1;
		end else if (instrWord[exec_pkg::NIBBLE_MSB:exec_pkg::NIBBLE_LSB]
				== exec_pkg::OPC_BIT_CLEAR_FILE) begin
			dec.opKind  = exec_pkg::OP_BIT_CLEAR_FILE;
			dec.updZero = 1'b0;
		end else if (instrWord[exec_pkg::OP6_MSB:exec_pkg::OP6_LSB]
				== exec_pkg::OPC_COMPLEMENT_FILE) begin
			dec.opKind  = exec_pkg::OP_COMPLEMENT_FILE;
			dec.updZero = 1'b1;
		end else if (instrWord[exec_pkg::OP6_MSB:exec_pkg::OP6_LSB]
				== exec_pkg::OPC_DECREMENT_FILE) begin
			dec.opKind  = exec_pkg::OP_DECREMENT_FILE;
			dec.updZero = 1'b1;
		end
	end

endmodule

`default_nettype wire

// file: sim/exec_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// execution result checks
// ************************************************************
module exec_checker (
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic        clkEn,
	input wire logic        instrValid,
	input wire logic [11:0] instrWord,
	input wire logic [7:0]  fileRdData,
	input wire logic        fileWrEn,
	input wire logic [4:0]  fileWrAddr,
	input wire logic [7:0]  fileWrData,
	input wire logic [7:0]  accumulator,
	input wire logic        zeroFlag,
	input wire logic        execDone,
	input wire logic        instrIgnored
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// taken words sorted by opcode field
	wire logic tk = clkEn && instrValid;
	wire logic isAnd = tk && instrWord[11:8] == exec_pkg::OPC_AND_LITERAL_ACC;
	wire logic isClr = tk && instrWord[11:8] == exec_pkg::OPC_BIT_CLEAR_FILE;
	wire logic isCom = tk && instrWord[11:6] == exec_pkg::OPC_COMPLEMENT_FILE;
	wire logic isDec = tk && instrWord[11:6] == exec_pkg::OPC_DECREMENT_FILE;
	wire logic known = isAnd || isClr || isCom || isDec;
	// result sits in the file write port or else in the accumulator
	wire logic [7:0] res = fileWrEn ? fileWrData : accumulator;
	sequence s_zero; zeroFlag == (res == 8'h00); endsequence
	property p_and; isAnd |=> accumulator ==
		($past(accumulator) & $past(instrWord[7:0])); endproperty
	a_and: assert property (p_and) else $error("and result");
	property p_clr; isClr |=> fileWrEn && $stable(zeroFlag) && fileWrData ==
		($past(fileRdData) & ~(8'h01 << $past(instrWord[7:5]))); endproperty
	a_clr: assert property (p_clr) else $error("bit clear");
	property p_addr; isClr |=> fileWrAddr == $past(instrWord[4:0]);
	endproperty
	a_addr: assert property (p_addr) else $error("clear address");
	property p_com; isCom |=> res == ~$past(fileRdData); endproperty
	a_com: assert property (p_com) else $error("complement");
	property p_dec; isDec |=> res == $past(fileRdData) - 8'h01; endproperty
	a_dec: assert property (p_dec) else $error("decrement");
	property p_dest; isCom || isDec |=> fileWrEn == $past(instrWord[5]);
	endproperty
	a_dest: assert property (p_dest) else $error("destination");
	property p_zero; isAnd || isCom || isDec |=> s_zero; endproperty
	a_zero: assert property (p_zero) else $error("zero flag");
	property p_done; known |=> execDone && !instrIgnored; endproperty
	a_done: assert property (p_done) else $error("retire strobe");
	property p_ign; tk && !known |=> instrIgnored && !execDone && !fileWrEn
		&& $stable(accumulator) && $stable(zeroFlag); endproperty
	a_ign: assert property (p_ign) else $error("unknown word");
endmodule
bind byte_logic_decrement_exec exec_checker props (.core_clk, .sys_rst,
	.clkEn, .instrValid, .instrWord, .fileRdData, .fileWrEn, .fileWrAddr,
	.fileWrData, .accumulator, .zeroFlag, .execDone, .instrIgnored);
`default_nettype wire

// file: sim/file_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// data register file of the core
// ************************************************************
module file_model (
	input wire logic       core_clk,
	input wire logic       clkEn,
	input wire logic       wrEn,
	input wire logic [4:0] wrAddr,
	input wire logic [7:0] wrData,
	input wire logic [4:0] rdAddr,
	output logic [7:0]     rdData
);
	logic [7:0] mem [32];
	// known start contents, mirrored by the bench model
	initial for (int i = 0; i < 32; i++) mem[i] = 8'(i * 37);
	// pending write bypassed so a back-to-back word reads fresh data
	assign rdData = (wrEn && wrAddr == rdAddr) ? wrData : mem[rdAddr];
	// commit only on enabled edges, as the core itself does
	always @(posedge core_clk) if (clkEn && wrEn) mem[wrAddr] <= wrData;
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// random instruction stream against a reference model
// ************************************************************
module tb;
	logic        core_clk = 0, sys_rst = 1, clkEn = 0, instrValid = 0;
	logic [11:0] instrWord = 12'h000, w;
	logic [7:0]  fileRdData, fileWrData, accumulator;
	logic [4:0]  fileWrAddr;
	logic        fileWrEn, zeroFlag, execDone, instrIgnored, v = 0, en = 0;
	int          errorCnt = 0, totalChecks = 0, cycles = 0;
	int          acc = 0, zf = 0, we = 0, wa = 0, wd = 0, mem [32];
	int          dn = 0, ig = 0;
	byte_logic_decrement_exec dut (.core_clk, .sys_rst, .clkEn, .instrValid,
		.instrWord, .fileRdData, .fileWrEn, .fileWrAddr, .fileWrData,
		.accumulator, .zeroFlag, .execDone, .instrIgnored);
	file_model partner (.core_clk, .clkEn, .wrEn(fileWrEn),
		.wrAddr(fileWrAddr), .wrData(fileWrData), .rdAddr(instrWord[4:0]),
		.rdData(fileRdData));
	// free running clock
	initial forever #25 core_clk = ~core_clk;
	// hang guard, well above the 3000 words of the run
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errorCnt++;
			endOfTest();
		end
	end
	task automatic chk(logic [7:0] got, int exp);
		totalChecks++;
		if (got !== exp[7:0]) begin
			errorCnt++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp[7:0]);
		end
	endtask
	task automatic chkBit(logic got, int exp);
		totalChecks++;
		if (got !== exp[0]) begin
			errorCnt++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp[0]);
		end
	endtask
	task endOfTest;
		$display("checks %0d errors %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// reference effect of one taken word; r < 0 means no file write
	task automatic apply(logic [11:0] x);
		int r;
		r = -1;
		dn = 1;
		if (x[11:8] == 4'he) begin
			acc &= x[7:0];
			zf = acc == 0;
		end else if (x[11:8] == 4'h4)
			r = mem[x[4:0]] & ~(1 << x[7:5]);
		else if (x[11:6] == 6'h09 || x[11:6] == 6'h03) begin
			r = (x[9] ? ~mem[x[4:0]] : mem[x[4:0]] - 1) & 255;
			zf = r == 0;
			if (!x[5]) begin
				acc = r;
				r = -1;
			end
		end else begin
			dn = 0;
		end
		ig = !dn;
		if (r >= 0) begin
			mem[x[4:0]] = r;
			we = 1;
			wa = x[4:0];
			wd = r;
		end
	endtask
	// main sequence: one word per edge, with stalls and idle cycles
	initial begin
		void'($urandom(32'h41cf));
		for (int i = 0; i < 32; i++) mem[i] = (i * 37) & 255;
		repeat (6) @(posedge core_clk);
		sys_rst <= 0;
		repeat (3000) begin
			@(posedge core_clk);
			if (en) begin
				we = 0;
				dn = 0;
				ig = 0;
			end
			if (en && v) apply(w);
			w = 12'($urandom);
			case ($urandom % 5)
				0: w[11:8] = 4'he;
				1: w[11:8] = 4'h4;
				2: w[11:6] = 6'h09;
				3: w[11:6] = 6'h03;
				default: ;
			endcase
			en = $urandom % 8 != 0;
			v = $urandom % 8 != 0;
			clkEn <= en;
			instrValid <= v;
			instrWord <= w;
			@(negedge core_clk);
			chk(accumulator, acc);
			chkBit(zeroFlag, zf);
			chkBit(fileWrEn, we);
			chkBit(execDone, dn);
			chkBit(instrIgnored, ig);
			if (we) begin
				chk({3'h0, fileWrAddr}, wa);
				chk(fileWrData, wd);
			end
		end
		endOfTest();
	end
endmodule
`default_nettype wire
